/* shared/stp_pkg.sv */
// Purpose: constants and types shared by both ends of the powerdown link
// Assumes: one 20 MHz clock for both ends
// Notes:   times are kept in their own unit, cycle counts derive from them

package stp_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 50;
   localparam int INACT_TIME_S    = 30;
   localparam int INACT_CYCLES    = INACT_TIME_S * (1000000000 / CLK_PERIOD_NS);
   localparam int INVALID_TIME_NS = 30000;
   localparam int INVALID_CYCLES  = (INVALID_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int VALID_TIME_NS   = 1000;
   localparam int VALID_CYCLES    = (VALID_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_TIME_NS    = 100000;
   localparam int WAKE_CYCLES     = WAKE_TIME_NS / CLK_PERIOD_NS;
   localparam int INACT_W         = 30;
   localparam int DET_W           = 10;
   localparam int WAKE_W          = 11;

   // ----------------------------------------------------------------
   // device shape
   // ----------------------------------------------------------------
   localparam int   N_TX             = 3;
   localparam int   N_RX             = 5;
   localparam int   N_PINS           = N_TX + 2 * N_RX + 3;
   localparam logic RX_OFF_IN_MANUAL = 1'b1;

   // ----------------------------------------------------------------
   // host registers, byte addresses and fields
   // ----------------------------------------------------------------
   localparam logic [3:0]  REG_CTRL        = 4'h0;
   localparam logic [3:0]  REG_STATUS      = 4'h4;
   localparam logic [3:0]  REG_IRQ_STATUS  = 4'h8;
   localparam logic [3:0]  REG_IRQ_MASK    = 4'hc;
   localparam int          CTRL_SHDN_BIT   = 0;
   localparam int          CTRL_KEEP_BIT   = 1;
   localparam int          CTRL_SCHEME_LSB = 2;
   localparam logic        CTRL_SHDN_RESET = 1'b1;
   localparam logic        CTRL_KEEP_RESET = 1'b1;
   localparam int          ST_READY_BIT    = 0;
   localparam int          ST_PRESENT_BIT  = 1;
   localparam int          IRQ_W           = 4;
   localparam int          IRQ_READY_UP    = 0;
   localparam int          IRQ_READY_DOWN  = 1;
   localparam int          IRQ_LOST        = 2;
   localparam int          IRQ_BACK        = 3;
   localparam logic [3:0]  IRQ_MASK_RESET  = 4'h0;

   typedef enum logic [1:0] {
      SCHEME_DIRECT = 2'b00,
      SCHEME_TIED   = 2'b01,
      SCHEME_CABLE  = 2'b11,
      SCHEME_HYBRID = 2'b10
   } stp_scheme_type;

   typedef enum logic [1:0] {
      PWR_OFF  = 2'b00,
      PWR_WAKE = 2'b01,
      PWR_ON   = 2'b11
   } stp_power_type;

endpackage

/* shared/stp_link_if.sv */
// Purpose: control and flag lines between host logic and transceiver
// Assumes: every line is driven by exactly one end
// Notes:   no clocking block, both ends sample with their own flops

`timescale 1ns/10ps

interface stp_link_if;
   logic keep_awake_input;
   logic shutdown_request_n;
   logic signal_absent_n;
   logic ready;

   modport dev  (input keep_awake_input, input shutdown_request_n, output signal_absent_n, output ready);
   modport host (output keep_awake_input, output shutdown_request_n, input signal_absent_n, input ready);
endinterface

/* hdl/stp_sync.sv */
// Purpose: three-flop input synchroniser with change pulse
// Assumes: pin_in is asynchronous to clk
// Notes:   a change counts once the second and third flops agree

`timescale 1ns/10ps

module stp_sync
   import stp_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic pin_in,
   output logic      level,
   output logic      toggled
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic toggled;
   } stp_sync_state_type;

   stp_sync_state_type q;
   stp_sync_state_type d;

   always_comb
   begin
      d         = q;
      d.s1      = pin_in;
      d.s2      = q.s1;
      d.s3      = q.s2;
      d.toggled = 1'b0;
      if ((q.s2 == q.s3) && (q.s3 != q.level))
      begin
         d.level   = q.s3;
         d.toggled = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         q <= '0;
      else
         q <= d;
   end

   assign level   = q.level;
   assign toggled = q.toggled;

endmodule

/* hdl/stp_device.sv */
// Purpose: powerdown control of a multi-channel line transceiver
// Assumes: control lines, line inputs and rail flag are asynchronous
// Notes:   analog pump and receiver thresholds arrive as digital flags

`timescale 1ns/10ps

module stp_device
   import stp_pkg::*;
#(
   parameter int INACT_CYCLES_P = INACT_CYCLES
)
(
   input  wire logic            clk,
   input  wire logic            reset_n,
   stp_link_if.dev              link,
   input  wire logic [N_TX-1:0] tx_in,
   input  wire logic [N_RX-1:0] rx_in,
   input  wire logic [N_RX-1:0] rx_valid,
   input  wire logic            rail_ok,
   output logic                 pump_en,
   output logic                 tx_out_en,
   output logic                 rx_out_en,
   output logic                 powered
);

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [N_PINS-1:0] pins;
   logic [N_PINS-1:0] pin_lvl;
   logic [N_PINS-1:0] pin_tgl;

   // shutdown goes through its flops inverted: their reset level then equals the idle high line,
   // so no false shutdown, and no receiver disable, follows reset
   assign pins = {rail_ok, link.keep_awake_input, ~link.shutdown_request_n, rx_valid, rx_in, tx_in};

   genvar gi;
   generate
      for (gi = 0; gi < N_PINS; gi++)
      begin : g_sync
         stp_sync u_sync
         (
            .clk     (clk),
            .reset_n (reset_n),
            .pin_in  (pins[gi]),
            .level   (pin_lvl[gi]),
            .toggled (pin_tgl[gi])
         );
      end
   endgenerate

   logic            activity;
   logic [N_RX-1:0] valid_lvl;
   logic            shdn_n_lvl;
   logic            keep_lvl;
   logic            keep_fell;
   logic            rail_lvl;

   // only line inputs count as activity; control lines do not
   assign activity   = |pin_tgl[N_TX+N_RX-1:0];
   assign valid_lvl  = pin_lvl[N_TX+2*N_RX-1:N_TX+N_RX];
   assign shdn_n_lvl = ~pin_lvl[N_TX+2*N_RX];
   assign keep_lvl   = pin_lvl[N_TX+2*N_RX+1];
   assign keep_fell  = pin_tgl[N_TX+2*N_RX+1] & ~keep_lvl;
   assign rail_lvl   = pin_lvl[N_TX+2*N_RX+2];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      stp_power_type      power;
      logic [INACT_W-1:0] idle_cnt;
      logic               expired;
      logic [WAKE_W-1:0]  wake_cnt;
      logic [DET_W-1:0]   det_cnt;
      logic               absent_n;
      logic               ready;
      logic               pump_en;
      logic               tx_en;
      logic               rx_en;
   } stp_dev_state_type;

   stp_dev_state_type q;
   stp_dev_state_type d;

   logic             power_req;
   logic             all_invalid;
   logic             pending;
   logic [DET_W-1:0] det_limit;

   always_comb
   begin
      d = q;

      // -------------------------------------------------------------
      // inactivity timer
      // -------------------------------------------------------------
      if (!shdn_n_lvl)
      begin
         // manual powerdown leaves the timer timed out
         d.idle_cnt = '0;
         d.expired  = 1'b1;
      end
      else if (keep_lvl || keep_fell || activity)
      begin
         // keep high pins the timer, its fall starts a full interval
         d.idle_cnt = '0;
         d.expired  = 1'b0;
         if (keep_fell)
            d.idle_cnt = '0;
      end
      else if (!q.expired)
      begin
         // counting runs only with keep low and shutdown high
         if (q.idle_cnt == INACT_W'(INACT_CYCLES_P - 1))
            d.expired = 1'b1;
         else
            d.idle_cnt = q.idle_cnt + INACT_W'(1);
      end

      // once expired, nothing but keep or an edge clears it
      power_req = shdn_n_lvl && (keep_lvl || !d.expired);

      // -------------------------------------------------------------
      // power sequencing
      // -------------------------------------------------------------
      case (q.power)
         PWR_OFF:
         begin
            d.wake_cnt = '0;
            if (power_req)
               d.power = PWR_WAKE;
         end
         PWR_WAKE:
         begin
            if (!power_req)
               d.power = PWR_OFF;
            else if (rail_lvl || (q.wake_cnt == WAKE_W'(WAKE_CYCLES - 1)))
               d.power = PWR_ON;
            else
               d.wake_cnt = q.wake_cnt + WAKE_W'(1);
         end
         PWR_ON:
         begin
            if (!power_req)
               d.power = PWR_OFF;
         end
         default:
            d.power = PWR_OFF;
      endcase

      d.pump_en = (d.power != PWR_OFF);
      d.tx_en   = (d.power == PWR_ON);
      d.ready   = (d.power == PWR_ON);
      d.rx_en   = !(RX_OFF_IN_MANUAL && !shdn_n_lvl);

      // -------------------------------------------------------------
      // signal-absent detector, independent of power state
      // -------------------------------------------------------------
      all_invalid = ~|valid_lvl;
      pending     = all_invalid ? q.absent_n : !q.absent_n;
      det_limit   = all_invalid ? DET_W'(INVALID_CYCLES) : DET_W'(VALID_CYCLES - 1);
      if (!pending)
         d.det_cnt = '0;
      else if (q.det_cnt == det_limit)
      begin
         // invalid must outlast the interval, valid needs it exactly
         d.absent_n = !all_invalid;
         d.det_cnt  = '0;
      end
      else
         d.det_cnt = q.det_cnt + DET_W'(1);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q          <= '0;
         q.power    <= PWR_OFF;
         q.expired  <= 1'b1;
         q.absent_n <= 1'b0;
         q.rx_en    <= 1'b1;
      end
      else
         q <= d;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.signal_absent_n = q.absent_n;
   assign link.ready           = q.ready;
   assign pump_en              = q.pump_en;
   assign tx_out_en            = q.tx_en;
   assign rx_out_en            = q.rx_en;
   assign powered              = q.pump_en;

endmodule

/* hdl/stp_host.sv */
// Purpose: host power management driving the transceiver controls
// Assumes: software on Avalon-MM, one wait state per access
// Notes:   scheme select picks how the two control lines are driven

`timescale 1ns/10ps

module stp_host
   import stp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   stp_link_if.host         link,
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   output logic             irq
);

   // ----------------------------------------------------------------
   // flag synchronisers
   // ----------------------------------------------------------------
   logic [1:0] flag_pins;
   logic [1:0] flag_lvl;
   logic [1:0] flag_tgl;

   assign flag_pins = {link.signal_absent_n, link.ready};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_sync
         stp_sync u_sync
         (
            .clk     (clk),
            .reset_n (reset_n),
            .pin_in  (flag_pins[gi]),
            .level   (flag_lvl[gi]),
            .toggled (flag_tgl[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic             ctrl_shdn;
      logic             ctrl_keep;
      stp_scheme_type   scheme;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_mask;
      logic [31:0]      rdata;
      logic             ack;
      logic             keep_out;
      logic             shdn_out;
      logic             irq;
   } stp_host_state_type;

   stp_host_state_type q;
   stp_host_state_type d;

   logic             accept;
   logic [IRQ_W-1:0] events;
   logic [IRQ_W-1:0] clear;

   always_comb
   begin
      d      = q;
      accept = (read || write) && q.ack;
      d.ack  = (read || write) && !q.ack;
      clear  = '0;

      // read data is prepared in the wait cycle
      if (read && !q.ack)
      begin
         d.rdata = '0;
         if (address == REG_CTRL)
            d.rdata[CTRL_SCHEME_LSB+1:0] = {q.scheme, q.ctrl_keep, q.ctrl_shdn};
         else if (address == REG_STATUS)
            d.rdata[ST_PRESENT_BIT:ST_READY_BIT] = flag_lvl;
         else if (address == REG_IRQ_STATUS)
            d.rdata[IRQ_W-1:0] = q.irq_status;
         else if (address == REG_IRQ_MASK)
            d.rdata[IRQ_W-1:0] = q.irq_mask;
      end

      if (accept && write)
      begin
         if (address == REG_CTRL)
         begin
            d.ctrl_shdn = writedata[CTRL_SHDN_BIT];
            d.ctrl_keep = writedata[CTRL_KEEP_BIT];
            d.scheme    = stp_scheme_type'(writedata[CTRL_SCHEME_LSB+1:CTRL_SCHEME_LSB]);
         end
         else if (address == REG_IRQ_MASK)
            d.irq_mask = writedata[IRQ_W-1:0];
      end

      // clear only the bits handed out; an event landing in the wait cycle stays pending
      if (accept && read && (address == REG_IRQ_STATUS))
         clear = q.rdata[IRQ_W-1:0];

      events                 = '0;
      events[IRQ_READY_UP]   = flag_tgl[0] & flag_lvl[0];
      events[IRQ_READY_DOWN] = flag_tgl[0] & ~flag_lvl[0];
      events[IRQ_LOST]       = flag_tgl[1] & ~flag_lvl[1];
      events[IRQ_BACK]       = flag_tgl[1] & flag_lvl[1];
      // a new event beats the read that clears it
      d.irq_status = (q.irq_status & ~clear) | events;
      d.irq        = |(d.irq_status & d.irq_mask);

      // -------------------------------------------------------------
      // control line drive per scheme
      // -------------------------------------------------------------
      case (q.scheme)
         SCHEME_DIRECT:
         begin
            // direct control: software drives both lines from ctrl_shdn and ctrl_keep
            d.shdn_out = q.ctrl_shdn;
            d.keep_out = q.ctrl_keep;
         end
         SCHEME_TIED:
         begin
            d.shdn_out = q.ctrl_shdn;
            d.keep_out = q.ctrl_shdn;
         end
         SCHEME_CABLE:
         begin
            d.shdn_out = flag_lvl[1];
            d.keep_out = flag_lvl[1];
         end
         SCHEME_HYBRID:
         begin
            d.shdn_out = flag_lvl[1];
            d.keep_out = 1'b0;
         end
         default:
         begin
            d.shdn_out = q.ctrl_shdn;
            d.keep_out = q.ctrl_keep;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q           <= '0;
         q.ctrl_shdn <= CTRL_SHDN_RESET;
         q.ctrl_keep <= CTRL_KEEP_RESET;
         q.scheme    <= SCHEME_DIRECT;
         q.irq_mask  <= IRQ_MASK_RESET;
         q.shdn_out  <= CTRL_SHDN_RESET;
         q.keep_out  <= CTRL_KEEP_RESET;
      end
      else
         q <= d;
   end

   assign waitrequest             = (read || write) && !q.ack;
   assign readdata                = q.rdata;
   assign irq                     = q.irq;
   assign link.shutdown_request_n = q.shdn_out;
   assign link.keep_awake_input   = q.keep_out;

endmodule

/* tb/stp_link_monitor.sv */
// Purpose: assertions on the powerdown link and device enables
// Assumes: one clock, reset_n asynchronous active low
// Notes:   raw-input counters time the flag delays, sync lag included
`timescale 1ns/10ps
module stp_link_monitor
   import stp_pkg::*;
(
   input wire logic            clk,
   input wire logic            reset_n,
   input wire logic            keep_awake_input,
   input wire logic            shutdown_request_n,
   input wire logic            signal_absent_n,
   input wire logic            ready,
   input wire logic [N_RX-1:0] rx_valid,
   input wire logic            pump_en,
   input wire logic            tx_out_en,
   input wire logic            rx_out_en
);
   logic [11:0] inv_q;
   logic [11:0] val_q;
   logic [11:0] wake_q;
   // counters saturate so a long idle stretch never wraps into a false match
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         inv_q  <= 12'h000;
         val_q  <= 12'h000;
         wake_q <= 12'h000;
      end
      else
      begin
         inv_q  <= (|rx_valid) ? 12'h000 : inv_q + 12'(inv_q != 12'hfff);
         val_q  <= (|rx_valid) ? val_q + 12'(val_q != 12'hfff) : 12'h000;
         wake_q <= (pump_en && !tx_out_en) ? wake_q + 12'(wake_q != 12'hfff) : 12'h000;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_shdn_forces_off: assert property ((!shutdown_request_n)[*8] |-> !pump_en && !tx_out_en && !ready)
      else $error("device on while shutdown requested");
   chk_rx_out_follow: assert property ($stable(shutdown_request_n)[*8] |-> rx_out_en == shutdown_request_n)
      else $error("receiver enable does not follow shutdown line");
   chk_ready_low_off: assert property ((!pump_en)[*3] |-> !ready)
      else $error("ready high with pump off");
   chk_ready_needs_pump: assert property ($rose(ready) |-> pump_en && $past(pump_en))
      else $error("ready rose without pump running");
   chk_wake_bound: assert property (wake_q <= WAKE_CYCLES + 4)
      else $error("wake took too long");
   chk_keep_stays_on: assert property ((keep_awake_input && shutdown_request_n)[*8] |-> pump_en)
      else $error("device off with keep-awake high");
   chk_absent_not_early: assert property ($fell(signal_absent_n) |-> inv_q >= INVALID_CYCLES)
      else $error("absent flag fell too early");
   chk_absent_in_time: assert property (inv_q == INVALID_CYCLES + 12 |-> !signal_absent_n)
      else $error("absent flag fell too late");
   chk_present_not_early: assert property ($rose(signal_absent_n) |-> val_q >= VALID_CYCLES)
      else $error("absent flag rose too early");
   chk_present_in_time: assert property (val_q == VALID_CYCLES + 10 |-> signal_absent_n)
      else $error("absent flag rose too late");
   cover property ($fell(pump_en));
   cover property ($rose(tx_out_en));
   cover property ($fell(signal_absent_n));
endmodule

/* tb/tb_top.sv */
// Purpose: both ends joined, software and line side driven by the bench
// Assumes: idle timer shortened to 200 cycles
// Notes:   rail model follows the pump after 40 cycles unless held stuck
`timescale 1ns/10ps
module tb_top
   import stp_pkg::*;
;
   logic            clk        = 1'b0;
   logic            reset_n    = 1'b0;
   logic [3:0]      address    = 4'h0;
   logic            read       = 1'b0;
   logic            write      = 1'b0;
   logic [31:0]     writedata  = 32'h0;
   logic [31:0]     readdata;
   logic [31:0]     rd;
   logic            waitrequest;
   logic            irq;
   logic            pump_en;
   logic            tx_out_en;
   logic            rx_out_en;
   logic            powered;
   logic [N_TX-1:0] tx_in      = '0;
   logic [N_RX-1:0] rx_in      = '0;
   logic [N_RX-1:0] rx_valid   = '1;
   logic            rail_ok    = 1'b0;
   logic            rail_stuck = 1'b0;
   logic [7:0]      rail_cnt   = 8'h00;
   int              bad_count  = 0;
   int              n_compared = 0;
   always #25 clk = ~clk;
   always @(posedge clk)
   begin
      rail_cnt <= pump_en ? rail_cnt + 8'(rail_cnt != 8'hff) : 8'h00;
      rail_ok  <= !rail_stuck && rail_cnt >= 8'h28;
   end
   stp_link_if link ();
   stp_device #(.INACT_CYCLES_P(200)) stp_device_inst (.clk(clk), .reset_n(reset_n), .link(link),
      .tx_in(tx_in), .rx_in(rx_in), .rx_valid(rx_valid), .rail_ok(rail_ok), .pump_en(pump_en),
      .tx_out_en(tx_out_en), .rx_out_en(rx_out_en), .powered(powered));
   stp_host stp_host_inst (.clk(clk), .reset_n(reset_n), .link(link), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq));
   stp_link_monitor stp_link_monitor_inst (.clk(clk), .reset_n(reset_n), .keep_awake_input(link.keep_awake_input),
      .shutdown_request_n(link.shutdown_request_n), .signal_absent_n(link.signal_absent_n), .ready(link.ready),
      .rx_valid(rx_valid), .pump_en(pump_en), .tx_out_en(tx_out_en), .rx_out_en(rx_out_en));
   task automatic print_verdict;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one request at a time, held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      read      <= !wr;
      write     <= wr;
      address   <= a;
      writedata <= d;
      i = 0;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (waitrequest !== 1'b0 && i < 50);
      rd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      if (i >= 50)
      begin
         bad_count++;
         $display("mismatch at %0t: bus wait ran out", $time);
         print_verdict;
      end
   endtask
   function automatic logic sel(input int k);
      return (k == 0) ? pump_en : (k == 1) ? link.ready : link.signal_absent_n;
   endfunction
   task automatic wait_for(input int k, input logic v, input int lim, output int n);
      n = 0;
      @(negedge clk);
      while (sel(k) !== v)
      begin
         n++;
         if (n > lim)
         begin
            bad_count++;
            $display("mismatch at %0t: wait ran out", $time);
            print_verdict;
         end
         @(negedge clk);
      end
   endtask
   task automatic s_reset;
      int n;
      bus(1'b0, REG_CTRL, 32'h0);
      check(rd, 32'h3);
      bus(1'b0, REG_IRQ_MASK, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, 4'h2, 32'hffffffff);
      bus(1'b0, 4'h2, 32'h0);
      check(rd, 32'h0);
      wait_for(1, 1'b1, 2100, n);
      check(tx_out_en, 1'b1);
   endtask
   task automatic s_manual;
      int n;
      bus(1'b1, REG_CTRL, 32'h2);
      wait_for(0, 1'b0, 20, n);
      check(n <= 8, 1'b1);
      check(rx_out_en, 1'b0);
      check(link.ready, 1'b0);
      check(powered, 1'b0);
      bus(1'b1, REG_CTRL, 32'h3);
      wait_for(1, 1'b1, WAKE_CYCLES + 20, n);
      check(tx_out_en, 1'b1);
   endtask
   task automatic s_auto;
      int n;
      bus(1'b1, REG_CTRL, 32'h1);
      wait_for(0, 1'b0, 300, n);
      check(n >= 195 && n <= 220, 1'b1);
      tick(300);
      @(negedge clk);
      check(pump_en, 1'b0);
      @(posedge clk);
      tx_in[1] <= ~tx_in[1];
      wait_for(0, 1'b1, 10, n);
      repeat (4)
      begin
         tick(150);
         rx_in[2] <= ~rx_in[2];
      end
      @(negedge clk);
      check(pump_en, 1'b1);
   endtask
   task automatic s_sticky;
      int n;
      bus(1'b1, REG_CTRL, 32'h0);
      wait_for(0, 1'b0, 20, n);
      bus(1'b1, REG_CTRL, 32'h1);
      tick(50);
      @(negedge clk);
      check(pump_en, 1'b0);
      bus(1'b1, REG_CTRL, 32'h3);
      wait_for(0, 1'b1, 20, n);
      tick(500);
      @(negedge clk);
      check(pump_en, 1'b1);
   endtask
   task automatic s_absent;
      int n;
      bus(1'b1, REG_IRQ_MASK, 32'h4);
      @(posedge clk);
      rx_valid <= '0;
      wait_for(2, 1'b0, 700, n);
      check(n >= INVALID_CYCLES && n <= INVALID_CYCLES + 12, 1'b1);
      check(pump_en, 1'b1);
      tick(8);
      @(negedge clk);
      check(irq, 1'b1);
      bus(1'b0, REG_IRQ_STATUS, 32'h0);
      check(rd[IRQ_LOST], 1'b1);
      bus(1'b0, REG_STATUS, 32'h0);
      check(rd[ST_PRESENT_BIT], 1'b0);
      tick(2);
      @(negedge clk);
      check(irq, 1'b0);
      @(posedge clk);
      rx_valid <= 5'h04;
      wait_for(2, 1'b1, 40, n);
      check(n >= VALID_CYCLES && n <= VALID_CYCLES + 8, 1'b1);
   endtask
   task automatic s_stuck;
      int n;
      @(posedge clk);
      rail_stuck <= 1'b1;
      bus(1'b1, REG_CTRL, 32'h2);
      wait_for(0, 1'b0, 20, n);
      bus(1'b1, REG_CTRL, 32'h3);
      wait_for(0, 1'b1, 20, n);
      wait_for(1, 1'b1, WAKE_CYCLES + 20, n);
      check(n >= WAKE_CYCLES - 10, 1'b1);
      @(posedge clk);
      rail_stuck <= 1'b0;
   endtask
   // tied, cable-detect and hybrid wiring of the two control lines
   task automatic s_schemes;
      int n;
      bus(1'b1, REG_CTRL, 32'h4);
      wait_for(0, 1'b0, 20, n);
      check(link.keep_awake_input, 1'b0);
      bus(1'b1, REG_CTRL, 32'h5);
      wait_for(0, 1'b1, 20, n);
      check(link.keep_awake_input, 1'b1);
      bus(1'b1, REG_CTRL, 32'hc);
      rx_valid <= '0;
      wait_for(0, 1'b0, 700, n);
      check(link.keep_awake_input, 1'b0);
      @(posedge clk);
      rx_valid <= 5'h01;
      wait_for(0, 1'b1, 60, n);
      bus(1'b1, REG_CTRL, 32'h8);
      rx_valid <= '0;
      wait_for(2, 1'b0, 700, n);
      tick(10);
      @(negedge clk);
      check(link.shutdown_request_n, 1'b0);
      check(link.keep_awake_input, 1'b0);
      check(pump_en, 1'b0);
      @(posedge clk);
      rx_valid <= '1;
      wait_for(2, 1'b1, 60, n);
      tick(20);
      @(negedge clk);
      check(link.shutdown_request_n, 1'b1);
      check(pump_en, 1'b0);
      @(posedge clk);
      tx_in[0] <= ~tx_in[0];
      wait_for(0, 1'b1, 12, n);
   endtask
   initial
   begin
      tick(20);
      reset_n <= 1'b1;
      s_reset;
      s_manual;
      s_auto;
      s_sticky;
      s_absent;
      s_stuck;
      s_schemes;
      print_verdict;
   end
endmodule
